// File: dv/ilpc_seq_model.sv
// sequencer model: instruction boundaries, return and mask pulses
`timescale 1ns/1ps
module ilpc_seq_model (
	input  wire logic  aclk,
	output logic       insn_fetch,
	output logic [1:0] insn_kind,
	output logic       insn_done,
	output logic       rti_done,
	output logic       rti_mask,
	output logic       mask_clr
);
	initial
	begin
		insn_fetch = 1'b0;
		insn_kind = 2'h0;
		insn_done = 1'b0;
		rti_done = 1'b0;
		rti_mask = 1'b1;
		mask_clr = 1'b0;
	end

	task run_insn(input logic [1:0] k);
		@(posedge aclk);
		insn_fetch <= 1'b1;
		insn_kind <= k;
		@(posedge aclk);
		insn_fetch <= 1'b0;
		// kind means nothing between fetches, so do not leave it looking valid
		insn_kind <= ~k;
		repeat (2) @(posedge aclk);
		insn_done <= 1'b1;
		@(posedge aclk);
		insn_done <= 1'b0;
	endtask

	task rti_ret(input logic m);
		@(posedge aclk);
		rti_done <= 1'b1;
		rti_mask <= m;
		@(posedge aclk);
		rti_done <= 1'b0;
		rti_mask <= ~m;
	endtask

	task clr_mask();
		@(posedge aclk);
		mask_clr <= 1'b1;
		@(posedge aclk);
		mask_clr <= 1'b0;
	endtask
endmodule // ilpc_seq_model

// File: dv/ilpc_top_test.sv
// self-checking bench for the interrupt and low-power control block
`timescale 1ns/1ps
module ilpc_top_test;
	logic        aclk, aresetn, irq_n_pin, mask_set;
	logic        tmr_ovf_flag, tmr_ovf_en, tmr_rt_flag, tmr_rt_en, per_flag, per_en;
	logic        insn_fetch, insn_done, rti_done, rti_mask, mask_clr;
	logic [1:0]  insn_kind;
	logic        take_valid, mask_out, osc_enable, cpu_run, timer_run, watchdog_run, irq;
	logic [15:0] take_vector;
	logic [2:0]  take_src;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
	logic [3:0]  s_axi_wstrb;
	int          err_total, checks_done, cyc;

	ilpc_top ilpc_top_inst (.aclk, .aresetn, .irq_n_pin, .insn_fetch, .insn_kind, .insn_done,
		.rti_done, .rti_mask, .mask_set, .mask_clr, .tmr_ovf_flag, .tmr_ovf_en, .tmr_rt_flag,
		.tmr_rt_en, .per_flag, .per_en, .take_valid, .take_vector, .take_src, .mask_out,
		.osc_enable, .cpu_run, .timer_run, .watchdog_run, .irq, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	ilpc_seq_model ilpc_seq_model_inst (.aclk, .insn_fetch, .insn_kind, .insn_done, .rti_done,
		.rti_mask, .mask_clr);

	always #20 aclk = ~aclk;

	// ----------------------------------------------------------------
	// bus and check tasks
	// ----------------------------------------------------------------
	task chk(input bit ok, input string m);
		checks_done++;
		if (!ok)
		begin
			err_total++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask

	task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// a take is a single-cycle pulse, so every edge of the window is looked at
	task chk_take(input bit want, input logic [15:0] v);
		bit got;
		got = 1'b0;
		repeat (10)
		begin
			@(posedge aclk);
			if (take_valid === 1'b1 && !got)
			begin
				got = 1'b1;
				chk(take_vector === v || !want, "wrong take vector");
			end
		end
		chk(got == want, "take presence wrong");
	endtask

	task give_verdict();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			err_total++;
			give_verdict();
		end
	end

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial
	begin
		{aclk, aresetn, mask_set, tmr_ovf_flag, tmr_ovf_en, tmr_rt_flag, tmr_rt_en} = '0;
		{per_flag, per_en, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{err_total, checks_done, cyc} = '0;
		irq_n_pin = 1'b1;
		s_axi_wstrb = 4'hF;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		chk(mask_out === 1'b1 && take_vector === 16'h1FFC && cpu_run === 1'b1, "reset");
		axi_rd(ilpc_pkg::REG_CONFIG, rd, rr);
		chk(rd === 32'h3 && rr === ilpc_pkg::RESP_OKAY, "config");
		tmr_ovf_flag <= 1'b1;
		tmr_ovf_en <= 1'b1;
		ilpc_seq_model_inst.run_insn(ilpc_pkg::OP_OTHER);
		chk_take(1'b0, 16'h0000);
		tmr_ovf_en <= 1'b0;
		ilpc_seq_model_inst.clr_mask();
		ilpc_seq_model_inst.run_insn(ilpc_pkg::OP_OTHER);
		chk_take(1'b0, 16'h0000);
		tmr_ovf_en <= 1'b1;
		ilpc_seq_model_inst.run_insn(ilpc_pkg::OP_TRAP);
		chk_take(1'b1, ilpc_pkg::VEC_TMR);
		chk(mask_out === 1'b1, "mask after take");
		tmr_ovf_flag <= 1'b0;
		ilpc_seq_model_inst.run_insn(ilpc_pkg::OP_OTHER);
		chk_take(1'b1, ilpc_pkg::VEC_TRAP);
		chk(take_src === ilpc_pkg::SRC_TRAP, "trap source");
		tmr_rt_flag <= 1'b1;
		tmr_rt_en <= 1'b1;
		irq_n_pin <= 1'b0;
		ilpc_seq_model_inst.rti_ret(1'b0);
		repeat (4) @(posedge aclk);
		ilpc_seq_model_inst.run_insn(ilpc_pkg::OP_OTHER);
		chk_take(1'b1, ilpc_pkg::VEC_EXT);
		irq_n_pin <= 1'b1;
		ilpc_seq_model_inst.rti_ret(1'b0);
		ilpc_seq_model_inst.run_insn(ilpc_pkg::OP_OTHER);
		chk_take(1'b1, ilpc_pkg::VEC_TMR);
		chk(take_src === ilpc_pkg::SRC_TMR, "timer source");
		{tmr_rt_flag, per_flag, per_en} <= 3'h3;
		ilpc_seq_model_inst.rti_ret(1'b0);
		ilpc_seq_model_inst.run_insn(ilpc_pkg::OP_OTHER);
		chk_take(1'b1, ilpc_pkg::VEC_PER);
		ilpc_seq_model_inst.run_insn(ilpc_pkg::OP_STOP);
		@(posedge aclk);
		chk({osc_enable, timer_run, watchdog_run, cpu_run} === 4'h0, "stop halt");
		chk(mask_out === 1'b0, "stop mask");
		tmr_ovf_flag <= 1'b1;
		chk_take(1'b0, 16'h0000);
		irq_n_pin <= 1'b0;
		chk_take(1'b1, ilpc_pkg::VEC_EXT);
		{irq_n_pin, tmr_ovf_flag, per_flag} <= 3'h4;
		chk(cpu_run === 1'b1, "woke");
		ilpc_seq_model_inst.run_insn(ilpc_pkg::OP_WAIT);
		@(posedge aclk);
		chk({cpu_run, timer_run, mask_out} === 3'h2, "wait entry");
		tmr_ovf_flag <= 1'b1;
		chk_take(1'b1, ilpc_pkg::VEC_TMR);
		tmr_ovf_flag <= 1'b0;
		irq_n_pin <= 1'b0;
		repeat (5) @(posedge aclk);
		irq_n_pin <= 1'b1;
		ilpc_seq_model_inst.run_insn(ilpc_pkg::OP_OTHER);
		chk_take(1'b0, 16'h0000);
		ilpc_seq_model_inst.rti_ret(1'b0);
		ilpc_seq_model_inst.run_insn(ilpc_pkg::OP_OTHER);
		chk_take(1'b1, ilpc_pkg::VEC_EXT);
		ilpc_seq_model_inst.rti_ret(1'b0);
		mask_set <= 1'b1;
		@(posedge aclk);
		mask_set <= 1'b0;
		@(posedge aclk);
		chk(mask_out === 1'b1, "mask set pulse");
		// status, mask, level output and an unmapped place
		chk(irq === 1'b0, "irq masked");
		axi_rd(ilpc_pkg::REG_IRQ_STATUS, rd, rr);
		chk(rd === 32'hF, "events seen");
		axi_wr(ilpc_pkg::REG_IRQ_MASK, 32'h1, rr);
		repeat (2) @(posedge aclk);
		chk(irq === 1'b1, "irq raised");
		axi_wr(ilpc_pkg::REG_IRQ_STATUS, 32'hF, rr);
		repeat (2) @(posedge aclk);
		chk(irq === 1'b0, "irq cleared");
		axi_wr(8'h40, 32'hFF, rr);
		chk(rr === ilpc_pkg::RESP_SLVERR, "unmapped write");
		axi_rd(8'h40, rd, rr);
		chk(rd === 32'h0 && rr === ilpc_pkg::RESP_SLVERR, "unmapped read");
		give_verdict();
	end
endmodule // ilpc_top_test

// File: verilog/ilpc_ext_if.sv
// link between the external request pin stage and the arbitration core
`timescale 1ns/1ps
interface ilpc_ext_if;
	logic req;
	logic latched;
	logic clear;

	modport pin  (output req, output latched, input clear);
	modport core (input req, input latched, output clear);
endinterface

// File: verilog/ilpc_ext_pin.sv
// external request pin: synchroniser, falling edge latch and trigger option
`timescale 1ns/1ps
module ilpc_ext_pin #(
	parameter bit LEVEL_MODE = 1'b1
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic irq_n_pin,
	ilpc_ext_if.pin   ext
);

	logic sync1_q;
	logic sync2_q;
	logic hist_q;
	logic latch_q;
	logic sync1_d;
	logic sync2_d;
	logic hist_d;
	logic latch_d;
	logic fall;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		sync1_d = irq_n_pin;
		sync2_d = sync1_q;
		hist_d  = sync2_q;
		fall    = hist_q & ~sync2_q;
		// a new edge beats the clear
		latch_d = fall | (latch_q & ~ext.clear);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
			hist_q  <= 1'b1;
			latch_q <= 1'b0;
		end
		else
		begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
			hist_q  <= hist_d;
			latch_q <= latch_d;
		end
	end

	// level adds a held low pin
	// level taken from the edge stage so one fall is never served twice
	assign ext.req     = latch_q | (LEVEL_MODE & ~hist_q);
	assign ext.latched = latch_q;

endmodule // ilpc_ext_pin

// File: verilog/ilpc_pkg.sv
// constants, types and helpers shared by the interrupt and low-power control block
package ilpc_pkg;

	// ----------------------------------------------------------------
	// interrupt vector locations (low byte address of each pair)
	// ----------------------------------------------------------------
	localparam logic [15:0] VEC_TRAP = 16'h1FFC;
	localparam logic [15:0] VEC_EXT  = 16'h1FFA;
	localparam logic [15:0] VEC_TMR  = 16'h1FF8;
	localparam logic [15:0] VEC_PER  = 16'h1FF6;

	// ----------------------------------------------------------------
	// hardware request vector positions
	// ----------------------------------------------------------------
	localparam int HW_EXT = 0;
	localparam int HW_TMR = 1;
	localparam int HW_PER = 2;
	localparam int HW_N   = 3;

	// ----------------------------------------------------------------
	// instruction kinds reported by the sequencer at fetch
	// ----------------------------------------------------------------
	localparam logic [1:0] OP_OTHER = 2'h0;
	localparam logic [1:0] OP_TRAP  = 2'h1;
	localparam logic [1:0] OP_STOP  = 2'h2;
	localparam logic [1:0] OP_WAIT  = 2'h3;

	typedef enum logic [2:0] {SRC_NONE, SRC_EXT, SRC_TMR, SRC_PER, SRC_TRAP} ilpc_src_t;
	typedef enum logic [1:0] {ST_RUN, ST_STOP, ST_WAIT} ilpc_state_t;

	// ----------------------------------------------------------------
	// register map (byte addresses) and fields
	// ----------------------------------------------------------------
	localparam int          ADDR_W         = 8;
	localparam logic [7:0]  REG_STATE      = 8'h00;
	localparam logic [7:0]  REG_IRQ_STATUS = 8'h04;
	localparam logic [7:0]  REG_IRQ_MASK   = 8'h08;
	localparam logic [7:0]  REG_CONFIG     = 8'h0C;

	localparam int          EV_TAKE  = 0;
	localparam int          EV_STOP  = 1;
	localparam int          EV_WAIT  = 2;
	localparam int          EV_WAKE  = 3;
	localparam int          EV_N     = 4;
	localparam logic [3:0]  EV_RESET = 4'h0;

	localparam int          ST_F_MASK  = 0;
	localparam int          ST_F_HW    = 1;
	localparam int          ST_F_LATCH = 4;
	localparam int          ST_F_TRAP  = 5;
	localparam int          ST_F_STATE = 6;

	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// fixed priority: external, then timer, then periodic
	function automatic ilpc_src_t pick_src(input logic [HW_N-1:0] req);
		if (req[HW_EXT])
			return SRC_EXT;
		else if (req[HW_TMR])
			return SRC_TMR;
		else if (req[HW_PER])
			return SRC_PER;
		return SRC_NONE;
	endfunction

	function automatic logic [15:0] vector_of(input ilpc_src_t src);
		unique case (src)
			SRC_EXT: return VEC_EXT;
			SRC_TMR: return VEC_TMR;
			SRC_PER:  return VEC_PER;
			SRC_TRAP: return VEC_TRAP;
			default:  return VEC_TRAP;
		endcase
	endfunction

	function automatic logic reg_known(input logic [ADDR_W-1:0] a);
		return (a == REG_STATE) || (a == REG_IRQ_STATUS) ||
			(a == REG_IRQ_MASK) || (a == REG_CONFIG);
	endfunction

endpackage

// File: verilog/ilpc_top.sv
// interrupt arbitration and stop/wait control with an AXI4-Lite register port
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module ilpc_top #(
	parameter bit LEVEL_MODE  = 1'b1,
	parameter bit STOP_ENABLE = 1'b1
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        irq_n_pin,
	input  wire logic        insn_fetch,
	input  wire logic [1:0]  insn_kind,
	input  wire logic        insn_done,
	input  wire logic        rti_done,
	input  wire logic        rti_mask,
	input  wire logic        mask_set,
	input  wire logic        mask_clr,
	input  wire logic        tmr_ovf_flag,
	input  wire logic        tmr_ovf_en,
	input  wire logic        tmr_rt_flag,
	input  wire logic        tmr_rt_en,
	input  wire logic        per_flag,
	input  wire logic        per_en,
	output logic             take_valid,
	output logic [15:0]      take_vector,
	output logic [2:0]       take_src,
	output logic             mask_out,
	output logic             osc_enable,
	output logic             cpu_run,
	output logic             timer_run,
	output logic             watchdog_run,
	output logic             irq,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	// ----------------------------------------------------------------
	// external pin stage
	// ----------------------------------------------------------------
	ilpc_ext_if ext ();

	ilpc_ext_pin #(
		.LEVEL_MODE (LEVEL_MODE)
	) u_ext (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.irq_n_pin (irq_n_pin),
		.ext       (ext.pin)
	);

	// ----------------------------------------------------------------
	// request forming
	// ----------------------------------------------------------------
	logic [ilpc_pkg::HW_N-1:0] hw_raw;
	logic [ilpc_pkg::HW_N-1:0] hw_gated;
	logic                      mask_q;

	always_comb
	begin
		hw_raw[ilpc_pkg::HW_EXT] = ext.req;
		hw_raw[ilpc_pkg::HW_TMR] = (tmr_ovf_flag & tmr_ovf_en) | (tmr_rt_flag & tmr_rt_en);
		hw_raw[ilpc_pkg::HW_PER] = per_flag & per_en;
		hw_gated = hw_raw & {ilpc_pkg::HW_N{~mask_q}};
	end

	// ----------------------------------------------------------------
	// arbitration and low-power state
	// ----------------------------------------------------------------
	ilpc_pkg::ilpc_state_t     state_q;
	ilpc_pkg::ilpc_state_t     state_d;
	ilpc_pkg::ilpc_src_t       src_q;
	ilpc_pkg::ilpc_src_t       src_d;
	ilpc_pkg::ilpc_src_t       pick;
	logic                      mask_d;
	logic [1:0]                op_q;
	logic [1:0]                op_d;
	logic [ilpc_pkg::HW_N-1:0] pre_q;
	logic [ilpc_pkg::HW_N-1:0] pre_d;
	logic                      trap_pend_q;
	logic                      trap_pend_d;
	logic                      take_q;
	logic                      take_d;
	logic [15:0]               vec_q;
	logic [15:0]               vec_d;
	logic [ilpc_pkg::EV_N-1:0] ev_set;

	always_comb
	begin
		state_d    = state_q;
		src_d      = src_q;
		mask_d     = mask_q;
		op_d       = op_q;
		pre_d      = pre_q;
		trap_pend_d = trap_pend_q;
		take_d     = 1'b0;
		vec_d      = vec_q;
		ev_set     = '0;
		pick       = ilpc_pkg::SRC_NONE;
		ext.clear  = 1'b0;
		// sequencer may only move the mask while running
		if (state_q == ilpc_pkg::ST_RUN)
		begin
			if (mask_set)
				mask_d = 1'b1;
			else if (mask_clr)
				mask_d = 1'b0;
			if (rti_done)
				mask_d = rti_mask;
			if (insn_fetch)
			begin
				op_d = insn_kind;
				if (insn_kind == ilpc_pkg::OP_TRAP)
					pre_d = hw_gated;
			end
		end
		unique case (state_q)
			ilpc_pkg::ST_RUN:
			begin
				if (insn_done)
				begin
					pre_d = '0;
					if (op_q == ilpc_pkg::OP_TRAP)
					begin
						// older hardware first, trap kept pending
						pick = ilpc_pkg::pick_src(pre_q & hw_gated);
						if (pick == ilpc_pkg::SRC_NONE)
							pick = ilpc_pkg::SRC_TRAP;
						else
							trap_pend_d = 1'b1;
					end
					else if (trap_pend_q)
					begin
						pick        = ilpc_pkg::SRC_TRAP;
						trap_pend_d = 1'b0;
					end
					// disabled stop falls through as no-operation
					else if ((op_q == ilpc_pkg::OP_STOP) && STOP_ENABLE)
					begin
						mask_d          = 1'b0;
						state_d         = ilpc_pkg::ST_STOP;
						ev_set[ilpc_pkg::EV_STOP] = 1'b1;
					end
					else if (op_q == ilpc_pkg::OP_WAIT)
					begin
						mask_d          = 1'b0;
						state_d         = ilpc_pkg::ST_WAIT;
						ev_set[ilpc_pkg::EV_WAIT] = 1'b1;
					end
					else
						pick = ilpc_pkg::pick_src(hw_gated);
					op_d = ilpc_pkg::OP_OTHER;
				end
			end
			ilpc_pkg::ST_STOP:
			begin
				if (hw_gated[ilpc_pkg::HW_EXT])
				begin
					pick    = ilpc_pkg::SRC_EXT;
					state_d = ilpc_pkg::ST_RUN;
					ev_set[ilpc_pkg::EV_WAKE] = 1'b1;
				end
			end
			ilpc_pkg::ST_WAIT:
			begin
				pick = ilpc_pkg::pick_src(hw_gated &
					ilpc_pkg::HW_N'((1 << ilpc_pkg::HW_EXT) | (1 << ilpc_pkg::HW_TMR)));
				if (pick != ilpc_pkg::SRC_NONE)
				begin
					state_d = ilpc_pkg::ST_RUN;
					ev_set[ilpc_pkg::EV_WAKE] = 1'b1;
				end
			end
			default:
				state_d = ilpc_pkg::ST_RUN;
		endcase
		if (pick != ilpc_pkg::SRC_NONE)
		begin
			take_d = 1'b1;
			mask_d = 1'b1;
			src_d  = pick;
			vec_d  = ilpc_pkg::vector_of(pick);
			ev_set[ilpc_pkg::EV_TAKE] = 1'b1;
			if (pick == ilpc_pkg::SRC_EXT)
				ext.clear = 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_q    <= ilpc_pkg::ST_RUN;
			src_q      <= ilpc_pkg::SRC_NONE;
			mask_q     <= 1'b1;
			op_q       <= ilpc_pkg::OP_OTHER;
			pre_q      <= '0;
			trap_pend_q <= 1'b0;
			take_q     <= 1'b0;
			vec_q      <= ilpc_pkg::VEC_TRAP;
		end
		else
		begin
			state_q    <= state_d;
			src_q      <= src_d;
			mask_q     <= mask_d;
			op_q       <= op_d;
			pre_q      <= pre_d;
			trap_pend_q <= trap_pend_d;
			take_q     <= take_d;
			vec_q      <= vec_d;
		end
	end

	assign take_valid   = take_q;
	assign take_vector  = vec_q;
	assign take_src     = src_q;
	assign mask_out     = mask_q;
	// stop halts clock, timer and watchdog
	assign osc_enable   = (state_q != ilpc_pkg::ST_STOP);
	assign timer_run    = (state_q != ilpc_pkg::ST_STOP);
	assign watchdog_run = (state_q != ilpc_pkg::ST_STOP);
	assign cpu_run      = (state_q == ilpc_pkg::ST_RUN);

	// ----------------------------------------------------------------
	// register port
	// ----------------------------------------------------------------
	// write address and data are taken together; one answer outstanding each way
	logic [ilpc_pkg::EV_N-1:0] evst_q;
	logic [ilpc_pkg::EV_N-1:0] evst_d;
	logic [ilpc_pkg::EV_N-1:0] evmask_q;
	logic [ilpc_pkg::EV_N-1:0] evmask_d;
	logic                      bvalid_q;
	logic                      bvalid_d;
	logic [1:0]                bresp_q;
	logic [1:0]                bresp_d;
	logic                      rvalid_q;
	logic                      rvalid_d;
	logic [1:0]                rresp_q;
	logic [1:0]                rresp_d;
	logic [31:0]               rdata_q;
	logic [31:0]               rdata_d;
	logic                      wr_go;
	logic                      rd_go;
	logic [ilpc_pkg::EV_N-1:0] w1c;

	assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
	assign rd_go         = s_axi_arvalid & ~rvalid_q;
	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;
	assign s_axi_arready = rd_go;

	always_comb
	begin
		evmask_d = evmask_q;
		bvalid_d = bvalid_q & ~s_axi_bready;
		bresp_d  = bresp_q;
		rvalid_d = rvalid_q & ~s_axi_rready;
		rresp_d  = rresp_q;
		rdata_d  = rdata_q;
		w1c      = '0;
		if (wr_go)
		begin
			bvalid_d = 1'b1;
			bresp_d  = ilpc_pkg::reg_known(s_axi_awaddr) ? ilpc_pkg::RESP_OKAY
				: ilpc_pkg::RESP_SLVERR;
			if (s_axi_wstrb[0] && (s_axi_awaddr == ilpc_pkg::REG_IRQ_STATUS))
				w1c = s_axi_wdata[ilpc_pkg::EV_N-1:0];
			if (s_axi_wstrb[0] && (s_axi_awaddr == ilpc_pkg::REG_IRQ_MASK))
				evmask_d = s_axi_wdata[ilpc_pkg::EV_N-1:0];
		end
		// a new event in the clearing cycle stays set
		evst_d = (evst_q & ~w1c) | ev_set;
		if (rd_go)
		begin
			rvalid_d = 1'b1;
			rresp_d  = ilpc_pkg::reg_known(s_axi_araddr) ? ilpc_pkg::RESP_OKAY
				: ilpc_pkg::RESP_SLVERR;
			rdata_d  = '0;
			unique case (s_axi_araddr)
				ilpc_pkg::REG_STATE:
				begin
					rdata_d[ilpc_pkg::ST_F_MASK]                       = mask_q;
					rdata_d[ilpc_pkg::ST_F_HW +: ilpc_pkg::HW_N]       = hw_raw;
					rdata_d[ilpc_pkg::ST_F_LATCH]                      = ext.latched;
					rdata_d[ilpc_pkg::ST_F_TRAP]                       = trap_pend_q;
					rdata_d[ilpc_pkg::ST_F_STATE +: 2]                 = state_q;
				end
				ilpc_pkg::REG_IRQ_STATUS: rdata_d[ilpc_pkg::EV_N-1:0] = evst_q;
				ilpc_pkg::REG_IRQ_MASK:   rdata_d[ilpc_pkg::EV_N-1:0] = evmask_q;
				ilpc_pkg::REG_CONFIG:     rdata_d[1:0] = {STOP_ENABLE, LEVEL_MODE};
				default:                  rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			evst_q   <= ilpc_pkg::EV_RESET;
			evmask_q <= ilpc_pkg::EV_RESET;
			bvalid_q <= 1'b0;
			bresp_q  <= ilpc_pkg::RESP_OKAY;
			rvalid_q <= 1'b0;
			rresp_q  <= ilpc_pkg::RESP_OKAY;
			rdata_q  <= 32'h0000_0000;
		end
		else
		begin
			evst_q   <= evst_d;
			evmask_q <= evmask_d;
			bvalid_q <= bvalid_d;
			bresp_q  <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q  <= rresp_d;
			rdata_q  <= rdata_d;
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp  = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp  = rresp_q;
	assign s_axi_rdata  = rdata_q;
	assign irq          = |(evst_q & evmask_q);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_trap_nmi;
		(state_q == ilpc_pkg::ST_RUN) && insn_done && trap_pend_q && (op_q != ilpc_pkg::OP_TRAP)
			|=> take_q && (src_q == ilpc_pkg::SRC_TRAP);
	endproperty
	a_trap_nmi: assert property (p_trap_nmi) else $error("pending trap not taken");

	property p_trap_vec;
		take_q && (src_q == ilpc_pkg::SRC_TRAP) |-> (take_vector == ilpc_pkg::VEC_TRAP);
	endproperty
	a_trap_vec: assert property (p_trap_vec) else $error("trap vector wrong");

	property p_masked;
		take_q && (src_q != ilpc_pkg::SRC_TRAP)
			|-> !$past(mask_q) || ($past(state_q) != ilpc_pkg::ST_RUN);
	endproperty
	a_masked: assert property (p_masked) else $error("maskable taken while masked");

	property p_take_mask;
		take_q |-> mask_q ##1 (mask_q || $past(rti_done) || $past(mask_clr));
	endproperty
	a_take_mask: assert property (p_take_mask) else $error("mask not set on take");

	property p_ext_first;
		(state_q == ilpc_pkg::ST_RUN) && insn_done && !trap_pend_q && (op_q == ilpc_pkg::OP_OTHER)
			&& hw_gated[ilpc_pkg::HW_EXT] |=> take_q && (src_q == ilpc_pkg::SRC_EXT);
	endproperty
	a_ext_first: assert property (p_ext_first) else $error("external not served first");

	property p_stop_enter;
		(state_q == ilpc_pkg::ST_RUN) && insn_done && !trap_pend_q && STOP_ENABLE
			&& (op_q == ilpc_pkg::OP_STOP) |=> !mask_q && !osc_enable && !timer_run;
	endproperty
	a_stop_enter: assert property (p_stop_enter) else $error("stop entry wrong");

	property p_stop_hold;
		(state_q == ilpc_pkg::ST_STOP) && !ext.req |=> (state_q == ilpc_pkg::ST_STOP) && !take_q;
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("stop left without pin");

	property p_boundary;
		(state_q == ilpc_pkg::ST_RUN) && !insn_done |=> !take_q;
	endproperty
	a_boundary: assert property (p_boundary) else $error("take off boundary");

	property p_wait_wake;
		(state_q == ilpc_pkg::ST_WAIT) && hw_gated[ilpc_pkg::HW_TMR]
			|=> take_q && cpu_run && timer_run;
	endproperty
	a_wait_wake: assert property (p_wait_wake) else $error("timer did not end wait");

endmodule // ilpc_top
